/* File: rtl/stop_mode_power_state_control.sv */
// power state controller: run modes, stop and wait entry and exit, cpu clock divider
`include "clk_mode_defs.svh"

// Overview of operation
// - stop halts oscillators, cpu and peripheral clocks
// - externally clocked peripherals may wake from stop
// - stop request also sets divide-by-8, high drive
// - stop holds io; clock pin high on subclock
// - reset, nmi or enabled interrupt leaves stop
// - wake interrupt restarts cpu clock, then service
// - resume subclock, else same source divided by 8
// - pll mode only from and to high-speed
// - main oscillator off forces divide-by-8
// - optional side oscillators in low-speed and pll
// - divider decode: 8, else 1/2/4/16
// - select bits choose source; main_osc_off stops main oscillator
module stop_mode_power_state_control
  import clk_mode_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // software control port
  input  wire logic       ctrl_wr,
  input  wire clk_ctrl_t  ctrl_wdata,
  input  wire logic       wait_req,
  output clk_ctrl_t       ctrl,
  output logic            wr_refused,
  // interrupt controller state
  input  wire logic [2:0] irq_level,
  input  wire logic [2:0] proc_int_level,
  input  wire logic       global_int_enable,
  // wake pins, asynchronous
  input  wire logic       nmi_n,
  input  wire logic       irq_pin,
  // clock output pin source
  input  wire logic       clock_output_pin_sub_sel,
  input  wire logic       clock_output_pin_level,
  // state and clock controls
  output mode_t           mode,
  output clk_src_t        cpu_src,
  output logic [4:0]      cpu_div_ratio,
  output logic            cpu_clk_en,
  output logic            periph_clk_en,
  output logic            main_osc_run,
  output logic            sub_osc_run,
  output logic            onchip_osc_run,
  output logic            pll_run,
  output logic            io_hold,
  output logic            clock_output_pin,
  output logic            isr_start
);

  // allowed-transition matrix; same mode is allowed except in stop and wait, which allow nothing
  function automatic logic allowed(input mode_t cur, input mode_t nxt);
    logic ok;
    ok = (cur == nxt);
    unique case (cur)
      MODE_HIGH_MED:  ok = ok || nxt inside {MODE_LOW_SPEED, MODE_PLL, MODE_ONCHIP, MODE_STOP, MODE_WAIT};
      MODE_LOW_SPEED: ok = ok || nxt inside {MODE_HIGH_MED, MODE_LOW_POWER, MODE_STOP, MODE_WAIT};
      MODE_LOW_POWER: ok = ok || nxt inside {MODE_LOW_SPEED, MODE_STOP, MODE_WAIT};
      MODE_PLL:       ok = ok || (nxt == MODE_HIGH_MED);
      MODE_ONCHIP:    ok = ok || nxt inside {MODE_HIGH_MED, MODE_ONCHIP_LP, MODE_STOP, MODE_WAIT};
      MODE_ONCHIP_LP: ok = ok || nxt inside {MODE_ONCHIP, MODE_STOP, MODE_WAIT};
      MODE_STOP:      ok = 1'b0;
      MODE_WAIT:      ok = 1'b0;
    endcase
    return ok;
  endfunction

  // mode that a control word describes
  function automatic mode_t mode_of(input clk_ctrl_t c);
    mode_t m;
    m = MODE_HIGH_MED;
    if (c.stop_request)
      m = MODE_STOP;
    else if (c.subclock_select)
      m = c.main_osc_off ? MODE_LOW_POWER : MODE_LOW_SPEED;
    else if (c.pll_cpu_select)
      m = MODE_PLL;
    else if (c.onchip_osc_select)
      m = c.main_osc_off ? MODE_ONCHIP_LP : MODE_ONCHIP;
    return m;
  endfunction

  logic [1:0]            sync [`SYNC_DEPTH];
  logic [1:0]            pin_stable;
  mode_t                 saved_mode;
  logic [`DIV_CNT_W-1:0] div_cnt;

  // effective write: stop and main-oscillator-off both force divide-by-8
  clk_ctrl_t wr_eff;
  always_comb begin
    wr_eff = ctrl_wdata;
    wr_eff.div8_select = ctrl_wdata.div8_select | ctrl_wdata.stop_request
                       | ctrl_wdata.main_osc_off;
    wr_eff.osc_drive_high = ctrl_wdata.osc_drive_high | ctrl_wdata.stop_request;
  end

  // write and wait acceptance; halted modes take no writes
  wire   in_stop  = (mode == MODE_STOP);
  wire   in_halt  = in_stop || (mode == MODE_WAIT);
  mode_t target;
  assign target = mode_of(ctrl_wdata);
  wire   wr_ok    = ctrl_wr && allowed(mode, target);
  wire   wait_ok  = wait_req && !ctrl_wr && allowed(mode, MODE_WAIT);
  assign wr_refused = ctrl_wr && !wr_ok;

  // wake sources: nmi pin, or an enabled peripheral request from an external-clocked unit
  wire   irq_wake = pin_stable[`PIN_IRQ] && (irq_level != `INT_LVL_OFF)
                  && (irq_level > proc_int_level) && global_int_enable;
  wire   wake     = in_halt && (pin_stable[`PIN_NMI] || irq_wake);

  // exit restores the pre-halt mode; stop drops its request bit
  clk_ctrl_t exit_ctrl;
  always_comb begin
    exit_ctrl = ctrl;
    exit_ctrl.stop_request = 1'b0;
  end

  mode_t     next_mode;
  clk_ctrl_t next_ctrl;
  assign next_mode = wake ? saved_mode : wait_ok ? MODE_WAIT : wr_ok ? target : mode;
  assign next_ctrl = wr_ok ? wr_eff : wake ? exit_ctrl : ctrl;

  // pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `SYNC_DEPTH; i++)
        sync[i] <= 2'h0;
      pin_stable <= 2'h0;
    end else begin
      sync[0] <= {irq_pin, ~nmi_n};
      for (int i = 1; i < `SYNC_DEPTH; i++)
        sync[i] <= sync[i-1];
      if (sync[1] == sync[2])
        pin_stable <= sync[2];
    end
  end

  // mode and control state; hardware reset is itself a stop exit
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mode       <= MODE_HIGH_MED;
      ctrl       <= `CTRL_RESET;
      saved_mode <= MODE_HIGH_MED;
      isr_start  <= 1'b0;
    end else begin
      mode      <= next_mode;
      ctrl      <= next_ctrl;
      isr_start <= wake && irq_wake;
      if (!in_halt && next_mode inside {MODE_STOP, MODE_WAIT})
        saved_mode <= mode;
    end
  end

  // source select and divider decode; the subclock bypasses the divider
  assign cpu_src = ctrl.subclock_select   ? SRC_SUB    :
                   ctrl.pll_cpu_select    ? SRC_PLL    :
                   ctrl.onchip_osc_select ? SRC_ONCHIP : SRC_MAIN;
  wire [1:0] div_code = {ctrl.cpu_div_high, ctrl.cpu_div_low};
  wire [4:0] code_ratio = (div_code == `DIV_CODE_1) ? `DIV_BY_1 :
                          (div_code == `DIV_CODE_2) ? `DIV_BY_2 :
                          (div_code == `DIV_CODE_4) ? `DIV_BY_4 : `DIV_BY_16;
  assign cpu_div_ratio = (cpu_src == SRC_SUB) ? `DIV_BY_1 :
                         ctrl.div8_select ? `DIV_BY_8 : code_ratio;

  // cpu clock enable: one pulse per ratio cycles, none while halted
  wire [`DIV_CNT_W-1:0] div_last = 4'(cpu_div_ratio - 5'h01);
  assign cpu_clk_en = !in_halt && (div_cnt == div_last);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      div_cnt <= '0;
    else if (in_halt || cpu_clk_en || div_cnt > div_last)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 4'h1;
  end

  // oscillators: all off in stop; side oscillators optional in low-speed and pll
  assign periph_clk_en  = !in_stop;
  assign main_osc_run   = !in_stop && !ctrl.main_osc_off;
  assign sub_osc_run    = !in_stop && (ctrl.sub_osc_on || ctrl.subclock_select);
  assign onchip_osc_run = !in_stop && (ctrl.onchip_osc_on || ctrl.onchip_osc_select);
  assign pll_run        = !in_stop && ctrl.pll_on;
  assign io_hold        = in_stop;

  // clock pin: follows its level outside stop; in stop high on subclock, otherwise frozen at its last level
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      clock_output_pin <= 1'b0;
    else if (!in_stop)
      clock_output_pin <= clock_output_pin_level;
    else if (clock_output_pin_sub_sel)
      clock_output_pin <= 1'b1;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_stop_halts_clk: assert property (in_stop |-> !cpu_clk_en && !periph_clk_en
    && !main_osc_run && !sub_osc_run && !onchip_osc_run && !pll_run)
    else $error("clock running in stop");
  a_stop_entry_bits: assert property (wr_ok && ctrl_wdata.stop_request
    |=> in_stop && ctrl.div8_select && ctrl.osc_drive_high)
    else $error("stop entry bits wrong");
  a_wake_leaves_halt: assert property (wake |=> !in_halt && mode == $past(saved_mode))
    else $error("wake did not leave halt");
  a_isr_after_wake: assert property (isr_start |-> $past(in_halt) && !in_halt
    ##1 (cpu_clk_en || !in_halt))
    else $error("service start without wake");
  a_resume_div8: assert property ($fell(in_stop) && cpu_src != SRC_SUB
    |-> cpu_div_ratio == `DIV_BY_8)
    else $error("resume not divided by 8");
  a_pll_entry_exit: assert property ((mode == MODE_PLL) != $past(mode == MODE_PLL)
    |-> (mode == MODE_HIGH_MED || $past(mode) == MODE_HIGH_MED))
    else $error("pll mode entered or left illegally");
  a_refused_keeps: assert property (wr_refused && !wake |=> mode == $past(mode)
    && ctrl == $past(ctrl))
    else $error("refused write changed state");
  a_osc_off_div8: assert property (wr_ok && ctrl_wdata.main_osc_off |=> ctrl.div8_select)
    else $error("oscillator off without divide by 8");
  a_div_decode: assert property (cpu_src != SRC_SUB && !ctrl.div8_select
    && div_code == `DIV_CODE_16 |-> cpu_div_ratio == `DIV_BY_16)
    else $error("divider decode wrong");
  a_clock_output_pin_stop: assert property (in_stop && $past(in_stop) && clock_output_pin_sub_sel |=> clock_output_pin)
    else $error("clock pin not high in stop");

  c_stop_nmi_exit: cover property (in_stop ##1 wake && pin_stable[`PIN_NMI] ##1 !in_stop);
  c_stop_irq_isr:  cover property (in_stop ##[1:20] isr_start);
  c_pll_round:     cover property (mode == MODE_PLL ##[1:50] mode == MODE_HIGH_MED);
  c_wr_refused:    cover property (wr_refused && mode == MODE_PLL);

endmodule

/* File: rtl/clk_mode_defs.svh */
// constants for the stop mode and power state controller
`ifndef CLK_MODE_DEFS_SVH
`define CLK_MODE_DEFS_SVH

// divider ratios and their width
`define DIV_RATIO_W   5
`define DIV_CNT_W     4
`define DIV_BY_1      5'h01
`define DIV_BY_2      5'h02
`define DIV_BY_4      5'h04
`define DIV_BY_8      5'h08
`define DIV_BY_16     5'h10

// two-bit divider codes
`define DIV_CODE_1    2'h0
`define DIV_CODE_2    2'h1
`define DIV_CODE_4    2'h2
`define DIV_CODE_16   2'h3

// interrupt priority code meaning disabled
`define INT_LVL_OFF   3'h0

// synchroniser depth for pin inputs
`define SYNC_DEPTH    3
`define PIN_NMI       0
`define PIN_IRQ       1

// control reset value: main clock, divide by 8, all else clear
`define CTRL_RESET    13'h0800

`endif

/* File: rtl/clk_mode_pkg.sv */
// types shared by the stop mode and power state controller
package clk_mode_pkg;

  typedef enum logic [2:0] {
    MODE_HIGH_MED,
    MODE_LOW_SPEED,
    MODE_LOW_POWER,
    MODE_PLL,
    MODE_ONCHIP,
    MODE_ONCHIP_LP,
    MODE_STOP,
    MODE_WAIT
  } mode_t;

  typedef enum logic [1:0] {
    SRC_MAIN,
    SRC_SUB,
    SRC_ONCHIP,
    SRC_PLL
  } clk_src_t;

  // software-visible control bits, written as one word
  typedef struct packed {
    logic       stop_request;
    logic       div8_select;
    logic       osc_drive_high;
    logic       osc_stop_detect_en;
    logic       pll_cpu_select;
    logic       pll_on;
    logic       main_osc_off;
    logic       subclock_select;
    logic       onchip_osc_select;
    logic       sub_osc_on;
    logic       onchip_osc_on;
    logic       cpu_div_high;
    logic       cpu_div_low;
  } clk_ctrl_t;

endpackage

/* File: tb/stop_mode_power_state_control_bench.sv */
// self-checking bench for the stop mode and power state controller
module stop_mode_power_state_control_bench import clk_mode_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic       core_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       ctrl_wr = 1'b0;
  clk_ctrl_t  ctrl_wdata = '0;
  logic       wait_req = 1'b0;
  logic [2:0] irq_level = 3'h0;
  logic [2:0] proc_int_level = 3'h1;
  logic       global_int_enable = 1'b1;
  logic       nmi_n = 1'b1;
  logic       irq_pin = 1'b0;
  logic       clock_output_pin_sub_sel = 1'b1;
  logic       clock_output_pin_level = 1'b0;
  clk_ctrl_t  ctrl, w;
  mode_t      mode;
  clk_src_t   cpu_src;
  logic [4:0] cpu_div_ratio;
  logic       wr_refused, cpu_clk_en, periph_clk_en, main_osc_run, sub_osc_run;
  logic       onchip_osc_run, pll_run, io_hold, clock_output_pin, isr_start;
  int         num_errors = 0;
  int         tests_run = 0;
  int         en_cnt;
  logic [4:0] div_exp [4] = '{5'h01, 5'h02, 5'h04, 5'h10};

  // 125 MHz core clock
  always #4 core_clk = ~core_clk;

  stop_mode_power_state_control DUT (
    .core_clk(core_clk), .rstn(rstn), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .wait_req(wait_req),
    .ctrl(ctrl), .wr_refused(wr_refused), .irq_level(irq_level), .proc_int_level(proc_int_level),
    .global_int_enable(global_int_enable), .nmi_n(nmi_n), .irq_pin(irq_pin),
    .clock_output_pin_sub_sel(clock_output_pin_sub_sel), .clock_output_pin_level(clock_output_pin_level), .mode(mode), .cpu_src(cpu_src),
    .cpu_div_ratio(cpu_div_ratio), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .main_osc_run(main_osc_run), .sub_osc_run(sub_osc_run), .onchip_osc_run(onchip_osc_run),
    .pll_run(pll_run), .io_hold(io_hold), .clock_output_pin(clock_output_pin), .isr_start(isr_start));

  // compare with case equality so unknowns never match
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // one write strobe, driven at the falling edge, refusal sampled before the taking edge
  task automatic wr(input clk_ctrl_t d, input logic refused);
    @(negedge core_clk);
    ctrl_wr    = 1'b1;
    ctrl_wdata = d;
    #1 chk("wr_refused", wr_refused, refused);
    @(negedge core_clk);
    ctrl_wr = 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // count cpu clock pulses over n cycles, sampled while each one stands
  task automatic count_en(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge core_clk);
      c += cpu_clk_en;
    end
  endtask

  // bounded wait: pins pass three sync stages before they count
  task automatic wait_wake();
    int n = 0;
    while ((mode === MODE_STOP || mode === MODE_WAIT) && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 20) chk("wake", 1'b0, 1'b1);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // whole run is under two hundred cycles
  initial begin
    #20000;
    num_errors++;
    conclude();
  end

  initial begin
    idle(2);
    rstn = 1'b1;
    chk("mode", mode, MODE_HIGH_MED);
    chk("ctrl", ctrl, 13'h0800);
    chk("ratio", cpu_div_ratio, 5'h08);
    chk("osc_runs", {main_osc_run, sub_osc_run, onchip_osc_run, pll_run}, 4'h8);
    $display("test reset done");
    // every divider code, then divide-by-8 overriding code 11
    for (int i = 0; i < 4; i++) begin
      w = '0;
      {w.cpu_div_high, w.cpu_div_low} = 2'(i);
      wr(w, 1'b0);
      chk("ratio", cpu_div_ratio, div_exp[i]);
    end
    // divide by 16 gives exactly two pulses in any 32 cycles
    count_en(32, en_cnt);
    chk("cpu_en_16", en_cnt, 32'd2);
    w.div8_select = 1'b1;
    wr(w, 1'b0);
    chk("ratio", cpu_div_ratio, 5'h08);
    $display("test divider done");
    // low speed, low power, pll entry refused then taken, stop refused in pll
    w = '0;
    w.subclock_select = 1'b1;
    w.sub_osc_on = 1'b1;
    wr(w, 1'b0);
    chk("mode", mode, MODE_LOW_SPEED);
    chk("src", cpu_src, SRC_SUB);
    chk("sub_run", sub_osc_run, 1'b1);
    count_en(8, en_cnt);
    chk("cpu_en_sub", en_cnt, 32'd8);
    w.main_osc_off = 1'b1;
    wr(w, 1'b0);
    chk("mode", mode, MODE_LOW_POWER);
    chk("div8", ctrl.div8_select, 1'b1);
    chk("main_run", main_osc_run, 1'b0);
    w.main_osc_off = 1'b0;
    wr(w, 1'b0);
    wr('{pll_cpu_select: 1'b1, pll_on: 1'b1, default: 1'b0}, 1'b1);
    chk("mode", mode, MODE_LOW_SPEED);
    wr('0, 1'b0);
    wr('{pll_cpu_select: 1'b1, pll_on: 1'b1, default: 1'b0}, 1'b0);
    chk("mode", mode, MODE_PLL);
    chk("pll_run", pll_run, 1'b1);
    wr('{pll_cpu_select: 1'b1, pll_on: 1'b1, sub_osc_on: 1'b1, default: 1'b0}, 1'b0);
    chk("sub_run", sub_osc_run, 1'b1);
    wr('{pll_cpu_select: 1'b1, pll_on: 1'b1, stop_request: 1'b1, default: 1'b0}, 1'b1);
    chk("mode", mode, MODE_PLL);
    wr('0, 1'b0);
    chk("mode", mode, MODE_HIGH_MED);
    chk("pll_run", pll_run, 1'b0);
    $display("test transitions done");
    // stop from divide-by-1 main clock with code 11 written, subclock on the clock pin
    irq_level = 3'h3;
    wr('{stop_request: 1'b1, cpu_div_high: 1'b1, cpu_div_low: 1'b1, default: 1'b0}, 1'b0);
    chk("mode", mode, MODE_STOP);
    chk("drive", {ctrl.div8_select, ctrl.osc_drive_high}, 2'h3);
    chk("runs", {main_osc_run, sub_osc_run, onchip_osc_run, pll_run, periph_clk_en, cpu_clk_en}, 6'h0);
    chk("io_hold", io_hold, 1'b1);
    idle(1);
    chk("clkpin", clock_output_pin, 1'b1);
    wr('0, 1'b1);
    // no request pending: stop must hold
    idle(8);
    chk("mode", mode, MODE_STOP);
    irq_pin = 1'b1;
    wait_wake();
    chk("mode", mode, MODE_HIGH_MED);
    chk("isr", isr_start, 1'b1);
    chk("ratio", cpu_div_ratio, 5'h08);
    chk("stopreq", ctrl.stop_request, 1'b0);
    irq_pin = 1'b0;
    idle(6);
    $display("test stop irq done");
    // stop from subclock, divided clock on the pin holds, nmi wakes
    irq_level = 3'h0;
    wr('{subclock_select: 1'b1, sub_osc_on: 1'b1, default: 1'b0}, 1'b0);
    clock_output_pin_sub_sel = 1'b0;
    clock_output_pin_level   = 1'b1;
    idle(2);
    wr('{stop_request: 1'b1, subclock_select: 1'b1, sub_osc_on: 1'b1, default: 1'b0}, 1'b0);
    chk("mode", mode, MODE_STOP);
    clock_output_pin_level = 1'b0;
    idle(3);
    chk("clkpin", clock_output_pin, 1'b1);
    nmi_n = 1'b0;
    wait_wake();
    chk("mode", mode, MODE_LOW_SPEED);
    chk("src", cpu_src, SRC_SUB);
    chk("ratio", cpu_div_ratio, 5'h01);
    chk("isr", isr_start, 1'b0);
    nmi_n = 1'b1;
    idle(6);
    $display("test stop nmi done");
    // wait mode entered by pulse; low level and cleared enable refused, then a real wake
    @(negedge core_clk);
    wait_req = 1'b1;
    @(negedge core_clk);
    wait_req = 1'b0;
    chk("mode", mode, MODE_WAIT);
    chk("cpu_en", cpu_clk_en, 1'b0);
    irq_level = 3'h1;
    irq_pin = 1'b1;
    idle(8);
    chk("mode", mode, MODE_WAIT);
    irq_level = 3'h3;
    global_int_enable = 1'b0;
    idle(2);
    chk("mode", mode, MODE_WAIT);
    global_int_enable = 1'b1;
    wait_wake();
    chk("mode", mode, MODE_LOW_SPEED);
    chk("isr", isr_start, 1'b1);
    irq_pin = 1'b0;
    irq_level = 3'h0;
    idle(6);
    $display("test wait done");
    // on-chip oscillator: low-power variant, stop with nmi wake, back to main clock
    wr('0, 1'b0);
    wr('{onchip_osc_select: 1'b1, default: 1'b0}, 1'b0);
    chk("mode", mode, MODE_ONCHIP);
    chk("src", cpu_src, SRC_ONCHIP);
    chk("onchip_run", onchip_osc_run, 1'b1);
    wr('{onchip_osc_select: 1'b1, main_osc_off: 1'b1, default: 1'b0}, 1'b0);
    chk("mode", mode, MODE_ONCHIP_LP);
    chk("div8", ctrl.div8_select, 1'b1);
    wr('{onchip_osc_select: 1'b1, default: 1'b0}, 1'b0);
    chk("mode", mode, MODE_ONCHIP);
    chk("ratio", cpu_div_ratio, 5'h01);
    wr('{stop_request: 1'b1, onchip_osc_select: 1'b1, default: 1'b0}, 1'b0);
    chk("mode", mode, MODE_STOP);
    nmi_n = 1'b0;
    wait_wake();
    chk("mode", mode, MODE_ONCHIP);
    chk("ratio", cpu_div_ratio, 5'h08);
    nmi_n = 1'b1;
    idle(6);
    wr('{div8_select: 1'b1, default: 1'b0}, 1'b0);
    chk("mode", mode, MODE_HIGH_MED);
    chk("ratio", cpu_div_ratio, 5'h08);
    $display("test onchip done");
    conclude();
  end
endmodule
